// ===== logic/bsh_regs.vh
`ifndef BSH_REGS_VH
`define BSH_REGS_VH

`define BSH_IO_BASE_HI     10'h300
`define BSH_AM_A16_USR     6'h29
`define BSH_AM_A16_SUP     6'h2D
`define BSH_AM_A24_USR     6'h39
`define BSH_AM_A24_SUP     6'h3D

`define BSH_OFS_VECTOR     5'h00
`define BSH_OFS_INT_PEND   5'h01
`define BSH_OFS_STAT_CTRL  5'h02
`define BSH_OFS_MEM_OFFSET 5'h03
`define BSH_OFS_CMD_DATA   5'h04
`define BSH_OFS_CMD_ADDR   5'h05

`define BSH_CMD_HW_LIMIT   16'h0080
`define BSH_CMD_ASW        16'h0000
`define BSH_CMD_INT_EN     16'h0002
`define BSH_CMD_MON_ADDR   16'h0010
`define BSH_CMD_MON_DATA   16'h0012

`define BSH_ASW_DONE_BIT   11
`define BSH_SC_MEM_EN_BIT  15
`define BSH_SC_READY_BIT   3
`define BSH_SC_SELFT_BIT   2
`define BSH_SC_RESET_BIT   0
`define BSH_SC_LVL_HI      4
`define BSH_SC_LVL_LO      2
`define BSH_INT_A_BIT      0
`define BSH_INT_B_BIT      1

`define BSH_RESET_VECTOR   16'h000F
`define BSH_ZERO16         16'h0000
`endif

// ===== logic/bsh_dual_ram.v
`timescale 1ns/1ps
// two read/write ports with byte lanes; port b wins a same-address write clash
module bsh_dual_ram #(
	parameter AW = 17
) (
	input  wire          sys_clk,
	input  wire [AW-1:0] a_addr,
	input  wire [1:0]    a_we,
	input  wire [15:0]   a_wdata,
	output reg  [15:0]   a_rdata,
	input  wire [AW-1:0] b_addr,
	input  wire [1:0]    b_we,
	input  wire [15:0]   b_wdata,
	output reg  [15:0]   b_rdata
);
	reg [15:0] mem [0:(1<<AW)-1];

	always @(posedge sys_clk)
	begin
		if (a_we[0])
			mem[a_addr][7:0] <= a_wdata[7:0];
		if (a_we[1])
			mem[a_addr][15:8] <= a_wdata[15:8];
		if (b_we[0])
			mem[b_addr][7:0] <= b_wdata[7:0];
		if (b_we[1])
			mem[b_addr][15:8] <= b_wdata[15:8];
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
	end
endmodule // bsh_dual_ram

// ===== logic/bsh_backplane_slave.v
`timescale 1ns/1ps
`include "bsh_regs.vh"
module bsh_backplane_slave (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire [23:1] vme_addr,
	input  wire [5:0]  vme_am,
	input  wire        vme_as_n,
	input  wire        vme_ds0_n,
	input  wire        vme_ds1_n,
	input  wire        vme_lword_n,
	input  wire        vme_write_n,
	input  wire        vme_iack_n,
	input  wire        vme_iackin_n,
	output wire        vme_iackout_n,
	input  wire [15:0] vme_data_in,
	output reg  [15:0] vme_data_out,
	output wire        vme_data_oe,
	output wire        vme_dtack_n_out,
	output wire        vme_dtack_oe,
	output wire        vme_berr_n_out,
	output wire        vme_berr_oe,
	output wire [7:1]  vme_irq_n_out,
	output wire [7:1]  vme_irq_oe,
	input  wire [7:0]  jumper_base,
	input  wire        board_ready,
	input  wire        self_test_ok,
	input  wire        int_a_event,
	output reg         soft_reset,
	output reg         eng_cmd_req,
	output reg         eng_cmd_write,
	output reg  [15:0] eng_cmd_addr,
	output reg  [15:0] eng_cmd_data,
	input  wire        eng_data_load,
	input  wire [15:0] eng_data_in,
	input  wire        eng_done,
	input  wire [16:0] eng_mem_addr,
	input  wire [1:0]  eng_mem_we,
	input  wire [15:0] eng_mem_wdata,
	output wire [15:0] eng_mem_rdata,
	input  wire [4:0]  eng_rt_addr,
	input  wire [7:0]  eng_rt_word,
	output wire [15:0] eng_rt_rdata
);
	localparam ST_IDLE  = 2'b00;
	localparam ST_SETUP = 2'b01;
	localparam ST_ACK   = 2'b10;
	localparam ST_ERR   = 2'b11;

	function am_is;
		input [5:0] am;
		input [5:0] a;
		input [5:0] b;
		begin
			am_is = (am == a) || (am == b);
		end
	endfunction

	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [15:0] vector_reg;
	reg [15:0] offset_reg;
	reg        mem_en_reg;
	reg [2:0]  level_reg;
	reg [15:0] cmd_addr_reg;
	reg [15:0] cmd_data_reg;
	reg [1:0]  int_en_reg;
	reg [1:0]  int_pend_reg;
	reg        asw_done_reg;
	reg [12:0] mon_addr_reg;
	reg        is_io_reg;
	reg        is_iack_reg;
	reg [4:0]  io_ofs_reg;
	reg        wr_reg;
	reg [1:0]  lanes_reg;
	reg [16:0] mem_word_reg;

	wire        strobe     = ~vme_as_n & ~(vme_ds0_n & vme_ds1_n);
	wire [1:0]  lanes      = {~vme_ds1_n, ~vme_ds0_n};
	wire        io_am      = am_is(vme_am, `BSH_AM_A16_USR, `BSH_AM_A16_SUP);
	wire        mem_am     = io_am | am_is(vme_am, `BSH_AM_A24_USR, `BSH_AM_A24_SUP);
	wire        io_hit     = io_am & (vme_addr[15:6] == (`BSH_IO_BASE_HI + {2'b00, jumper_base}));
	wire        mem_hit    = ~io_hit & mem_am & mem_en_reg & (vme_addr[23:18] == offset_reg[15:10]);
	wire        cmd_is_hw  = cmd_addr_reg < `BSH_CMD_HW_LIMIT;
	wire [2:0]  irq_pend   = |(int_pend_reg & int_en_reg) ? level_reg : 3'b000;
	wire        iack_mine  = ~vme_iack_n & ~vme_iackin_n & strobe & (irq_pend != 3'b000)
	                         & (vme_addr[3:1] == irq_pend);
	wire        setup_io   = (state_reg == ST_SETUP) & is_io_reg;
	wire        io_wr      = setup_io & wr_reg;
	wire        io_rd      = setup_io & ~wr_reg;
	wire        data_wr    = io_wr & (io_ofs_reg == `BSH_OFS_CMD_DATA);
	wire        data_rd    = io_rd & (io_ofs_reg == `BSH_OFS_CMD_DATA);
	wire        host_mem   = (state_reg == ST_SETUP) & ~is_io_reg & ~is_iack_reg;
	wire [15:0] mem_rdata;
	wire [15:0] mon_rdata;
	wire [1:0]  mon_we     = (data_wr & (cmd_addr_reg == `BSH_CMD_MON_DATA)) ? 2'b11 : 2'b00;

	reg  [15:0] io_rdata;
	reg         passing_reg;

	assign vme_dtack_n_out = 1'b0;
	assign vme_berr_n_out  = 1'b0;
	assign vme_dtack_oe    = (state_reg == ST_ACK);
	assign vme_berr_oe     = (state_reg == ST_ERR);
	assign vme_data_oe     = (state_reg == ST_ACK) & ~wr_reg;
	assign vme_iackout_n   = ~passing_reg;

	genvar lv;
	generate
		for (lv = 1; lv <= 7; lv = lv + 1)
		begin : g_irq
			assign vme_irq_n_out[lv] = 1'b0;
			assign vme_irq_oe[lv]    = (irq_pend == lv);
		end
	endgenerate

	// host port sees byte lanes; the engine keeps the other port so it runs on its own
	// while idle the bus address goes straight to the array, so read data stands with the acknowledge
	bsh_dual_ram #(.AW(17)) u_main_ram (
		.sys_clk (sys_clk),
		.a_addr  ((state_reg == ST_IDLE) ? vme_addr[17:1] : mem_word_reg),
		.a_we    ((host_mem & wr_reg) ? lanes_reg : 2'b00),
		.a_wdata (vme_data_in),
		.a_rdata (mem_rdata),
		.b_addr  (eng_mem_addr),
		.b_we    (eng_mem_we),
		.b_wdata (eng_mem_wdata),
		.b_rdata (eng_mem_rdata)
	);

	// 32 terminals of 256 words each
	bsh_dual_ram #(.AW(13)) u_mon_ram (
		.sys_clk (sys_clk),
		.a_addr  (mon_addr_reg),
		.a_we    (mon_we),
		.a_wdata (vme_data_in),
		.a_rdata (mon_rdata),
		.b_addr  ({eng_rt_addr, eng_rt_word}),
		.b_we    (2'b00),
		.b_wdata (`BSH_ZERO16),
		.b_rdata (eng_rt_rdata)
	);

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE:
			if (strobe & ~vme_iack_n)
			begin
				if (iack_mine)
					state_next = ST_SETUP;
			end
			else if (strobe & (io_hit | mem_hit))
			begin
				if (~vme_lword_n)
					state_next = ST_ERR;
				else
					state_next = ST_SETUP;
			end
		ST_SETUP:
			state_next = ST_ACK;
		ST_ACK, ST_ERR:
			if (vme_ds0_n & vme_ds1_n)
				state_next = ST_IDLE;
		default:
			state_next = ST_IDLE;
		endcase
	end

	always @*
	begin
		case (io_ofs_reg)
		`BSH_OFS_VECTOR:
			io_rdata = vector_reg;
		`BSH_OFS_INT_PEND:
			io_rdata = {14'h0000, int_pend_reg};
		`BSH_OFS_STAT_CTRL:
		begin
			io_rdata = `BSH_ZERO16;
			io_rdata[`BSH_SC_MEM_EN_BIT] = mem_en_reg;
			io_rdata[`BSH_SC_READY_BIT]  = board_ready;
			io_rdata[`BSH_SC_SELFT_BIT]  = self_test_ok;
		end
		`BSH_OFS_MEM_OFFSET:
			io_rdata = offset_reg;
		`BSH_OFS_CMD_DATA:
			if (!cmd_is_hw)
				io_rdata = cmd_data_reg;
			else if (cmd_addr_reg == `BSH_CMD_ASW)
			begin
				io_rdata = `BSH_ZERO16;
				io_rdata[`BSH_ASW_DONE_BIT] = asw_done_reg;
			end
			else if (cmd_addr_reg == `BSH_CMD_INT_EN)
				io_rdata = {14'h0000, int_en_reg};
			else if (cmd_addr_reg == `BSH_CMD_MON_ADDR)
				io_rdata = {3'b000, mon_addr_reg};
			else if (cmd_addr_reg == `BSH_CMD_MON_DATA)
				io_rdata = mon_rdata;
			else
				io_rdata = `BSH_ZERO16;
		default:
			io_rdata = `BSH_ZERO16; // command address reads back zero: it is write-only
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_reg    <= ST_IDLE;
			is_io_reg    <= 1'b0;
			is_iack_reg  <= 1'b0;
			io_ofs_reg   <= 5'h00;
			wr_reg       <= 1'b0;
			lanes_reg    <= 2'b00;
			mem_word_reg <= 17'h00000;
			vme_data_out <= `BSH_ZERO16;
			passing_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			passing_reg <= ~vme_iack_n & ~vme_iackin_n & strobe & ~iack_mine & (state_reg == ST_IDLE);
			if (state_reg == ST_IDLE)
			begin
				is_io_reg    <= io_hit;
				is_iack_reg  <= ~vme_iack_n;
				io_ofs_reg   <= vme_addr[5:1];
				wr_reg       <= ~vme_write_n & vme_iack_n;
				lanes_reg    <= lanes;
				mem_word_reg <= vme_addr[17:1];
			end
			if (state_reg == ST_SETUP)
			begin
				if (is_iack_reg)
					vme_data_out <= vector_reg;
				else if (is_io_reg)
					vme_data_out <= io_rdata;
				else
					vme_data_out <= mem_rdata;
			end
		end
	end

	// register block also takes the board reset written through the control register
	always @(posedge sys_clk)
	begin
		soft_reset  <= ~reset & io_wr & (io_ofs_reg == `BSH_OFS_STAT_CTRL) & vme_data_in[`BSH_SC_RESET_BIT];
		eng_cmd_req <= 1'b0;
		if (reset | soft_reset)
		begin
			vector_reg    <= `BSH_RESET_VECTOR;
			offset_reg    <= `BSH_ZERO16;
			mem_en_reg    <= 1'b0;
			level_reg     <= 3'b000;
			cmd_addr_reg  <= `BSH_ZERO16;
			cmd_data_reg  <= `BSH_ZERO16;
			int_en_reg    <= 2'b00;
			int_pend_reg  <= 2'b00;
			asw_done_reg  <= 1'b0;
			mon_addr_reg  <= 13'h0000;
			eng_cmd_write <= 1'b0;
			eng_cmd_addr  <= `BSH_ZERO16;
			eng_cmd_data  <= `BSH_ZERO16;
		end
		else
		begin
			if (io_wr)
			begin
				case (io_ofs_reg)
				`BSH_OFS_VECTOR:
					vector_reg <= vme_data_in;
				`BSH_OFS_STAT_CTRL:
				begin
					mem_en_reg <= vme_data_in[`BSH_SC_MEM_EN_BIT];
					level_reg  <= vme_data_in[`BSH_SC_LVL_HI:`BSH_SC_LVL_LO];
				end
				`BSH_OFS_MEM_OFFSET:
					offset_reg <= {vme_data_in[15:10], 10'h000};
				`BSH_OFS_CMD_ADDR:
					cmd_addr_reg <= vme_data_in;
				default:
					cmd_addr_reg <= cmd_addr_reg;
				endcase
			end
			if (data_wr & cmd_is_hw)
			begin
				if (cmd_addr_reg == `BSH_CMD_INT_EN)
					int_en_reg <= vme_data_in[1:0];
				if (cmd_addr_reg == `BSH_CMD_MON_ADDR)
					mon_addr_reg <= vme_data_in[12:0];
			end
			// the engine is told as the data access is taken, in the first acknowledge cycle, before the host cycle ends
			if ((data_wr | data_rd) & ~cmd_is_hw)
			begin
				eng_cmd_req   <= 1'b1;
				eng_cmd_write <= wr_reg;
				eng_cmd_addr  <= cmd_addr_reg;
				eng_cmd_data  <= vme_data_in;
				if (wr_reg)
					cmd_data_reg <= vme_data_in;
			end
			if (eng_data_load)
				cmd_data_reg <= eng_data_in;
			if (eng_done)
				asw_done_reg <= 1'b1;
			else if (data_rd & (cmd_addr_reg == `BSH_CMD_ASW))
				asw_done_reg <= 1'b0;
			// events win over the acknowledge that clears them
			int_pend_reg[`BSH_INT_A_BIT] <= int_a_event |
				(int_pend_reg[`BSH_INT_A_BIT] & ~(is_iack_reg & (state_reg == ST_SETUP)));
			int_pend_reg[`BSH_INT_B_BIT] <= (eng_done & int_en_reg[`BSH_INT_B_BIT]) |
				(int_pend_reg[`BSH_INT_B_BIT] & ~(is_iack_reg & (state_reg == ST_SETUP)));
		end
	end
endmodule // bsh_backplane_slave

// ===== bench/bsh_chk.sv
`timescale 1ns/1ps
module bsh_chk (
	input wire        sys_clk,
	input wire        reset,
	input wire [23:1] vme_addr,
	input wire [5:0]  vme_am,
	input wire        vme_as_n,
	input wire        vme_ds0_n,
	input wire        vme_ds1_n,
	input wire        vme_lword_n,
	input wire        vme_write_n,
	input wire        vme_iack_n,
	input wire        vme_iackin_n,
	input wire        vme_iackout_n,
	input wire        vme_data_oe,
	input wire        vme_dtack_oe,
	input wire        vme_berr_oe,
	input wire [7:1]  vme_irq_oe,
	input wire [7:0]  jumper_base,
	input wire        eng_cmd_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire ack = vme_dtack_oe | vme_berr_oe;
	wire am_ok = vme_am == 6'h29 || vme_am == 6'h2D || vme_am == 6'h39 || vme_am == 6'h3D;
	sequence s_io_take;
		$fell(vme_ds0_n) && !vme_as_n && vme_iack_n && vme_lword_n && vme_am == 6'h29
			&& vme_addr[15:6] == {2'b11, jumper_base};
	endsequence
	sequence s_ack_c2;
		!vme_dtack_oe ##1 !vme_dtack_oe ##1 vme_dtack_oe;
	endsequence
	a_io_ack_c2: assert property (s_io_take |-> s_ack_c2) else $error("register access not acked on c2");
	a_berr_long: assert property ($rose(vme_berr_oe) |-> !vme_lword_n) else $error("bus error on word access");
	a_dtack_word: assert property ($rose(vme_dtack_oe) |-> vme_lword_n) else $error("longword completed");
	a_ack_release: assert property (ack && vme_ds0_n && vme_ds1_n |-> ##[1:2] !ack) else $error("ack held");
	a_data_read: assert property (vme_data_oe |-> vme_dtack_oe && vme_write_n) else $error("data driven");
	a_irq_onehot: assert property ($onehot0(vme_irq_oe)) else $error("several request levels");
	a_roak_drop: assert property ($rose(vme_dtack_oe) && !vme_iack_n |-> ##[1:3] vme_irq_oe == 7'h00)
		else $error("request kept after acknowledge");
	a_iack_pass: assert property (!vme_iack_n && !vme_iackin_n && !vme_as_n && !(vme_ds0_n && vme_ds1_n)
		&& vme_irq_oe == 7'h00 && !vme_dtack_oe |=> !vme_iackout_n) else $error("acknowledge not passed on");
	a_bad_am_quiet: assert property (!vme_as_n && vme_iack_n && !am_ok |-> !ack) else $error("odd modifier acked");
	a_cmd_pulse: assert property (eng_cmd_req |=> !eng_cmd_req) else $error("command request too long");
endmodule // bsh_chk
bind bsh_backplane_slave bsh_chk bsh_chk_inst (.*);

// ===== bench/bsh_host.sv
`timescale 1ns/1ps
module bsh_host (
	input  wire        sys_clk,
	output logic [23:1] vme_addr,
	output logic [5:0] vme_am,
	output logic       vme_as_n,
	output logic       vme_ds0_n,
	output logic       vme_ds1_n,
	output logic       vme_lword_n,
	output logic       vme_write_n,
	output logic       vme_iack_n,
	output logic       vme_iackin_n,
	output wire [15:0] vme_data_in,
	input  wire [15:0] vme_data_out,
	input  wire        vme_data_oe,
	input  wire        vme_dtack_oe,
	input  wire        vme_berr_oe
);
	logic [15:0] drv = 16'h0000;
	// released data lines show the inverse of the last value, never a stale match
	assign vme_data_in = vme_data_oe ? vme_data_out : drv;
	initial {vme_addr, vme_am, vme_as_n, vme_ds0_n, vme_ds1_n, vme_lword_n, vme_write_n, vme_iack_n,
		vme_iackin_n} = {29'h0, 7'h7F};
	task cycle(input [5:0] am, input [23:1] a, input wr, input lw, input ia, input [15:0] wd,
		output [15:0] rd, output [1:0] rsp);
		int n;
		begin
			@(negedge sys_clk);
			{vme_am, vme_addr, vme_write_n, vme_lword_n, vme_iack_n, vme_iackin_n} = {am, a, !wr, !lw, !ia, !ia};
			drv = wr ? wd : ~drv;
			{vme_as_n, vme_ds0_n, vme_ds1_n} = 3'h0;
			rsp = 2'd0;
			rd = 16'h0000;
			for (n = 0; n < 12 && rsp == 2'd0; n++)
			begin
				@(posedge sys_clk);
				rsp = vme_berr_oe ? 2'd2 : vme_dtack_oe ? 2'd1 : 2'd0;
				// read data is taken at the edge that sees the acknowledge
				if (rsp == 2'd1)
					rd = vme_data_in;
			end
			@(negedge sys_clk);
			{vme_as_n, vme_ds0_n, vme_ds1_n, vme_iack_n, vme_iackin_n} = 5'h1F;
			for (n = 0; n < 12 && (vme_dtack_oe || vme_berr_oe); n++)
				@(posedge sys_clk);
		end
	endtask
endmodule // bsh_host

// ===== bench/bsh_backplane_slave_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: %h not %h", $time, g, e); end end
module bsh_backplane_slave_tb;
	logic        sys_clk = 0, reset = 1, board_ready = 0, self_test_ok = 0, int_a_event = 0;
	logic        eng_data_load = 0, eng_done = 0;
	logic [4:0]  eng_rt_addr = 5'h00;
	logic [7:0]  eng_rt_word = 8'h00;
	logic [7:0]  jumper_base = 8'h00;
	logic [15:0] eng_data_in = 16'h0000, rd, v, vec;
	logic [16:0] wa, eng_mem_addr = 17'h00000;
	logic [5:0]  ofs;
	logic [2:0]  lvl;
	logic [1:0]  rsp;
	logic [5:0]  ams [4] = '{6'h29, 6'h2D, 6'h39, 6'h3D};
	int          n_errors = 0, checked = 0, cyc = 0, n_soft = 0, i;
	wire [23:1]  vme_addr;
	wire [15:0]  vme_data_in, vme_data_out, eng_cmd_addr, eng_cmd_data, eng_mem_rdata, eng_rt_rdata;
	wire [7:1]   vme_irq_oe;
	wire [5:0]   vme_am;
	wire         vme_as_n, vme_ds0_n, vme_ds1_n, vme_lword_n, vme_write_n, vme_iack_n, vme_iackin_n;
	wire         vme_data_oe, vme_dtack_oe, vme_berr_oe, soft_reset, eng_cmd_req, eng_cmd_write;
	bsh_backplane_slave bsh_backplane_slave_inst (.*, .vme_iackout_n(), .vme_dtack_n_out(), .vme_berr_n_out(),
		.vme_irq_n_out(), .eng_mem_we(2'h0), .eng_mem_wdata(16'h0000));
	bsh_host bsh_host_inst (.*);
	always #50 sys_clk = ~sys_clk;
	// engine answers every command at once: read data is the inverted command address
	always @(negedge sys_clk)
	begin
		eng_data_load <= eng_cmd_req && !eng_cmd_write;
		eng_data_in <= ~eng_cmd_addr;
		eng_done <= eng_cmd_req;
	end
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (soft_reset === 1'b1)
			n_soft <= n_soft + 1;
		if (cyc == 8000)
		begin
			n_errors++;
			stop_test;
		end
	end
	function [23:1] io_a(input [7:0] o);
		reg [15:0] b;
		begin
			b = 16'hC000 + {jumper_base, 6'h00} + o;
			io_a = {8'h00, b[15:1]};
		end
	endfunction
	task acc(input [5:0] am, input [23:1] a, input wr, input lw, input ia, input [15:0] wd);
		bsh_host_inst.cycle(am, a, wr, lw, ia, wd, rd, rsp);
	endtask
	task wreg(input [7:0] o, input [15:0] d);
		acc(6'h29, io_a(o), 1, 0, 0, d);
		`CHK(rsp, 2'd1)
	endtask
	task rreg(input [7:0] o, input [15:0] e);
		acc(6'h29, io_a(o), 0, 0, 0, 16'h0000);
		`CHK(rsp, 2'd1)
		`CHK(rd, e)
	endtask
	task pulse_a;
		@(negedge sys_clk) int_a_event = 1;
		@(negedge sys_clk) int_a_event = 0;
		repeat (3) @(negedge sys_clk);
	endtask
	task stop_test;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		v = 16'($urandom(32'hC3CB55F8));
		{jumper_base, board_ready, self_test_ok, ofs, lvl} = 19'($urandom);
		lvl = 3'($urandom % 7 + 1);
		repeat (5) @(negedge sys_clk);
		reset = 0;
		rreg(8'h00, 16'h000F);
		rreg(8'h04, {12'h000, board_ready, self_test_ok, 2'b00});
		v = $urandom;
		wreg(8'h00, v);
		rreg(8'h00, v);
		acc(6'h29, io_a(8'h00), 0, 1, 0, 16'h0000);
		`CHK(rsp, 2'd2)
		acc(6'h09, io_a(8'h00), 0, 0, 0, 16'h0000);
		`CHK(rsp, 2'd0)
		$display("test registers done");
		wreg(8'h06, {ofs, 10'h000});
		acc(6'h39, {ofs, 17'h00000}, 0, 0, 0, 16'h0000);
		`CHK(rsp, 2'd0)
		wreg(8'h04, 16'h8000);
		acc(6'h3D, {ofs, 17'h00000}, 1, 1, 0, 16'h0000);
		`CHK(rsp, 2'd2)
		for (i = 0; i < 12; i++)
		begin
			// A15 kept low so the register window never claims the access
			wa = i == 0 ? 17'h00000 : i == 1 ? 17'h1BFFF : 17'($urandom) & 17'h1BFFF;
			v = $urandom;
			acc(ams[i % 4], {ofs, wa}, 1, 0, 0, v);
			`CHK(rsp, 2'd1)
			acc(ams[i % 4], {ofs, wa}, 0, 0, 0, 16'h0000);
			`CHK(rd, v)
		end
		@(negedge sys_clk);
		eng_mem_addr = wa;
		repeat (2) @(negedge sys_clk);
		`CHK(eng_mem_rdata, v)
		$display("test memory done");
		wreg(8'h0A, 16'h0100);
		acc(6'h29, io_a(8'h08), 0, 0, 0, 16'h0000);
		`CHK({eng_cmd_write, eng_cmd_addr}, 17'h00100)
		rreg(8'h08, 16'hFEFF);
		rreg(8'h0A, 16'h0000);
		wreg(8'h0A, 16'h0000);
		rreg(8'h08, 16'h0800);
		rreg(8'h08, 16'h0000);
		v = $urandom;
		wreg(8'h0A, 16'h0120);
		wreg(8'h08, v);
		`CHK({eng_cmd_write, eng_cmd_addr, eng_cmd_data}, {1'b1, 16'h0120, v})
		wreg(8'h0A, 16'h0000);
		rreg(8'h08, 16'h0800);
		wa = 17'($urandom) & 17'h01FFF;
		v = $urandom;
		wreg(8'h0A, 16'h0010);
		wreg(8'h08, wa[15:0]);
		rreg(8'h08, wa[15:0]);
		wreg(8'h0A, 16'h0012);
		wreg(8'h08, v);
		rreg(8'h08, v);
		@(negedge sys_clk);
		{eng_rt_addr, eng_rt_word} = wa[12:0];
		repeat (2) @(negedge sys_clk);
		`CHK(eng_rt_rdata, v)
		$display("test indirect done");
		vec = $urandom;
		wreg(8'h00, vec);
		wreg(8'h04, {11'h400, lvl, 2'b00});
		wreg(8'h0A, 16'h0002);
		wreg(8'h08, 16'h0003);
		for (i = 0; i < 2; i++)
		begin
			if (i == 0)
				pulse_a;
			else
			begin
				wreg(8'h0A, 16'h0120);
				wreg(8'h08, vec);
			end
			`CHK(vme_irq_oe, 7'h01 << (lvl - 3'd1))
			acc(6'h29, {20'h00000, lvl}, 0, 0, 1, 16'h0000);
			`CHK(rd, vec)
			`CHK(vme_irq_oe, 7'h00)
		end
		wreg(8'h0A, 16'h0002);
		wreg(8'h08, 16'h0002);
		pulse_a;
		`CHK(vme_irq_oe, 7'h00)
		acc(6'h29, {20'h00000, lvl}, 0, 0, 1, 16'h0000);
		`CHK(rsp, 2'd0)
		$display("test interrupts done");
		wreg(8'h04, 16'h0001);
		`CHK(n_soft, 1)
		rreg(8'h00, 16'h000F);
		$display("test soft reset done");
		stop_test;
	end
endmodule // bsh_backplane_slave_tb
